// file: src/pin_keeper.sv
module pin_keeper #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Pin side
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] driven_in,
  input  wire logic [W-1:0] own_oe_in,
  input  wire logic [W-1:0] own_val_in,
  // Held level
  output logic      [W-1:0] level_out
);

  // ---------------------------------------------------------------
  // Weak hold per pin: runs on during power-down; only reset stops it and clears it to 0
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_keep
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        level_out[i] <= 1'b0;
      end else if (driven_in[i]) begin
        level_out[i] <= pin_in[i];
      end else if (own_oe_in[i]) begin
        level_out[i] <= own_val_in[i];
      end
    end

    keeper_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !driven_in[i] && !own_oe_in[i] |=> $stable(level_out[i]))
      else $error("keeper lost an undriven level");
  end

endmodule

// file: src/pld_pkg.sv
package pld_pkg;

  // ---------------------------------------------------------------
  // Array sizes
  // ---------------------------------------------------------------
  localparam int MC_N       = 10;
  localparam int IN_N       = 12;
  localparam int SHARED_IDX = 3;
  localparam int ADDR_W     = 8;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] POL_OFS     = 8'h04;
  localparam logic [ADDR_W-1:0] PRELOAD_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] SIG_LO_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] SIG_HI_OFS  = 8'h14;

  localparam int CTRL_PD_EN_BIT  = 0;
  localparam int CTRL_SECURE_BIT = 1;
  localparam int STAT_PD_BIT     = 0;
  localparam int STAT_WIN_BIT    = 1;
  localparam int STAT_SEC_BIT    = 2;
  localparam int STAT_MC_LSB     = 16;

  localparam logic [MC_N-1:0] POL_RESET = 10'h000;
  localparam logic [63:0]     SIG_RESET = 64'h0000_0000_0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int RESET_WINDOW_NS = 1000;
  localparam int RESET_WINDOW_CYC =
    (RESET_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: src/pld_powerdown_reset_control.sv
module pld_powerdown_reset_control
  import pld_pkg::*;
#(
  parameter int RST_CYC = RESET_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic              MCLK_IN,
  input  wire logic              RST_IN,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
  input  wire logic              AXI_AWVALID_IN,
  output logic                   AXI_AWREADY_OUT,
  input  wire logic [31:0]       AXI_WDATA_IN,
  input  wire logic [3:0]        AXI_WSTRB_IN,
  input  wire logic              AXI_WVALID_IN,
  output logic                   AXI_WREADY_OUT,
  output logic [1:0]             AXI_BRESP_OUT,
  output logic                   AXI_BVALID_OUT,
  input  wire logic              AXI_BREADY_IN,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
  input  wire logic              AXI_ARVALID_IN,
  output logic                   AXI_ARREADY_OUT,
  output logic [31:0]            AXI_RDATA_OUT,
  output logic [1:0]             AXI_RRESP_OUT,
  output logic                   AXI_RVALID_OUT,
  input  wire logic              AXI_RREADY_IN,
  // Device pins
  input  wire logic              CLK_PIN_IN,
  input  wire logic [IN_N-1:0]   IN_PIN_IN,
  input  wire logic [IN_N-1:0]   IN_DRIVEN_IN,
  input  wire logic [MC_N-1:0]   IO_PIN_IN,
  input  wire logic [MC_N-1:0]   IO_DRIVEN_IN,
  output logic      [MC_N-1:0]   IO_OUT,
  output logic      [MC_N-1:0]   IO_OE_OUT,
  // Logic array side
  input  wire logic [MC_N-1:0]   MC_D_IN,
  input  wire logic [MC_N-1:0]   OE_TERM_IN,
  output logic [IN_N+MC_N-1:0]   ARRAY_OUT,
  output logic                   POWER_DOWN_OUT
);

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  logic [MC_N-1:0]   mc_r;
  logic [MC_N-1:0]   pol_r;
  logic [63:0]       sig_r;
  logic              pd_en_r;
  logic              secure_r;
  logic              clk_pin_d_r;
  logic [IN_N-1:0]   in_level;
  logic [MC_N-1:0]   io_level;
  logic              win_busy;
  logic              pd_act;
  logic              clk_rise;
  logic [IN_N-1:0]   in_masked;
  logic              aw_full_r;
  logic              w_full_r;
  logic              aw_full_nxt;
  logic              w_full_nxt;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              wr_go;
  logic              preload_go;
  logic              wr_ok;
  logic [31:0]       rd_data;
  logic [1:0]        rd_resp;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Reset window and pin keepers
  // ---------------------------------------------------------------
  powerup_window #(.CYCLES(RST_CYC)) u_win (
    .clk_in   (MCLK_IN),
    .rst_in   (RST_IN),
    .busy_out (win_busy)
  );

  // Keepers run on regardless of power-down so pins never float
  pin_keeper #(.W(IN_N)) u_in_keep (
    .clk_in     (MCLK_IN),
    .rst_in     (RST_IN),
    .pin_in     (IN_PIN_IN),
    .driven_in  (IN_DRIVEN_IN),
    .own_oe_in  ({IN_N{1'b0}}),
    .own_val_in ({IN_N{1'b0}}),
    .level_out  (in_level)
  );

  pin_keeper #(.W(MC_N)) u_io_keep (
    .clk_in     (MCLK_IN),
    .rst_in     (RST_IN),
    .pin_in     (IO_PIN_IN),
    .driven_in  (IO_DRIVEN_IN),
    .own_oe_in  (IO_OE_OUT),
    .own_val_in (IO_OUT),
    .level_out  (io_level)
  );

  // ---------------------------------------------------------------
  // Power-down and clock pin
  // ---------------------------------------------------------------
  // The shared pin is the only input still looked at in power-down
  assign pd_act   = pd_en_r & in_level[SHARED_IDX];
  // Edges inside the reset window are ignored; the board keeps it quiet
  assign clk_rise = CLK_PIN_IN & ~clk_pin_d_r & ~win_busy;

  always_comb begin
    in_masked = in_level;
    if (pd_en_r) begin
      in_masked[SHARED_IDX] = 1'b0;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      clk_pin_d_r <= 1'b0;
    end else begin
      clk_pin_d_r <= CLK_PIN_IN;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      POWER_DOWN_OUT <= 1'b0;
    end else begin
      POWER_DOWN_OUT <= pd_act;
    end
  end

  // ---------------------------------------------------------------
  // Macrocell registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || win_busy) begin
      mc_r <= '0;
    end else if (pd_act) begin
      mc_r <= mc_r;
    end else if (preload_go) begin
      mc_r <= w_data_r[MC_N-1:0];
    end else if (clk_rise) begin
      mc_r <= MC_D_IN;
    end
  end

  // Pins follow one cycle behind the registers; frozen while asleep
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      IO_OUT    <= POL_RESET;
      IO_OE_OUT <= '0;
      ARRAY_OUT <= '0;
    end else if (!pd_act) begin
      IO_OUT    <= mc_r ^ pol_r;
      IO_OE_OUT <= OE_TERM_IN;
      ARRAY_OUT <= {io_level, in_masked};
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign wr_go       = aw_full_r & w_full_r & ~AXI_BVALID_OUT;
  assign aw_full_nxt = (AXI_AWVALID_IN & AXI_AWREADY_OUT) | (aw_full_r & ~wr_go);
  assign w_full_nxt  = (AXI_WVALID_IN & AXI_WREADY_OUT) | (w_full_r & ~wr_go);
  // Preload is refused once secured and while the device is asleep
  assign preload_go  = wr_go & (aw_addr_r == PRELOAD_OFS) & ~secure_r & ~pd_act
                       & ~win_busy;
  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr_r == PRELOAD_OFS) begin
      wr_ok = ~secure_r & ~pd_act & ~win_busy;
    end else if (aw_addr_r == STATUS_OFS) begin
      wr_ok = 1'b0;
    end else if (aw_addr_r != CTRL_OFS && aw_addr_r != POL_OFS &&
                 aw_addr_r != SIG_LO_OFS && aw_addr_r != SIG_HI_OFS) begin
      wr_ok = 1'b0;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      aw_full_r       <= 1'b0;
      w_full_r        <= 1'b0;
      AXI_AWREADY_OUT <= 1'b0;
      AXI_WREADY_OUT  <= 1'b0;
    end else begin
      aw_full_r       <= aw_full_nxt;
      w_full_r        <= w_full_nxt;
      AXI_AWREADY_OUT <= ~aw_full_nxt;
      AXI_WREADY_OUT  <= ~w_full_nxt;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
      aw_addr_r <= AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
      w_data_r <= AXI_WDATA_IN;
      w_strb_r <= AXI_WSTRB_IN;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT  <= RESP_OKAY;
    end else if (wr_go) begin
      AXI_BVALID_OUT <= 1'b1;
      AXI_BRESP_OUT  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (AXI_BREADY_IN) begin
      AXI_BVALID_OUT <= 1'b0;
    end
  end
  // Configuration bits; the security bit is write-one-to-set and acts
  // on the very next request
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pd_en_r  <= 1'b0;
      secure_r <= 1'b0;
      pol_r    <= POL_RESET;
      sig_r    <= SIG_RESET;
    end else if (wr_go) begin
      if (aw_addr_r == CTRL_OFS && w_strb_r[0]) begin
        pd_en_r  <= w_data_r[CTRL_PD_EN_BIT];
        secure_r <= secure_r | w_data_r[CTRL_SECURE_BIT];
      end else if (aw_addr_r == POL_OFS) begin
        pol_r <= MC_N'(merge({{(32-MC_N){1'b0}}, pol_r}, w_data_r, w_strb_r));
      end else if (aw_addr_r == SIG_LO_OFS) begin
        sig_r[31:0] <= merge(sig_r[31:0], w_data_r, w_strb_r);
      end else if (aw_addr_r == SIG_HI_OFS) begin
        sig_r[63:32] <= merge(sig_r[63:32], w_data_r, w_strb_r);
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    rd_resp = RESP_OKAY;
    if (AXI_ARADDR_IN == CTRL_OFS || AXI_ARADDR_IN == POL_OFS) begin
      if (secure_r) begin
        rd_resp = RESP_SLVERR;
      end else if (AXI_ARADDR_IN == CTRL_OFS) begin
        rd_data[CTRL_PD_EN_BIT] = pd_en_r;
      end else begin
        rd_data[MC_N-1:0] = pol_r;
      end
    end else if (AXI_ARADDR_IN == STATUS_OFS) begin
      rd_data[STAT_PD_BIT]                   = pd_act;
      rd_data[STAT_WIN_BIT]                  = win_busy;
      rd_data[STAT_SEC_BIT]                  = secure_r;
      rd_data[STAT_MC_LSB +: MC_N]           = mc_r;
    end else if (AXI_ARADDR_IN == SIG_LO_OFS) begin
      rd_data = sig_r[31:0];
    end else if (AXI_ARADDR_IN == SIG_HI_OFS) begin
      rd_data = sig_r[63:32];
    end else if (AXI_ARADDR_IN != PRELOAD_OFS) begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT  <= 1'b0;
      AXI_RDATA_OUT   <= '0;
      AXI_RRESP_OUT   <= RESP_OKAY;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT  <= 1'b1;
      AXI_RDATA_OUT   <= rd_data;
      AXI_RRESP_OUT   <= rd_resp;
    end else if (AXI_RVALID_OUT) begin
      AXI_ARREADY_OUT <= AXI_RREADY_IN;
      AXI_RVALID_OUT  <= ~AXI_RREADY_IN;
    end else begin
      AXI_ARREADY_OUT <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  reset_clear_a: assert property (win_busy |=> mc_r == '0)
    else $error("registers not cleared in reset window");
  pin_polarity_a: assert property (!pd_act |=> IO_OUT == $past(mc_r ^ pol_r))
    else $error("pin level does not match register and polarity");
  preload_load_a: assert property (preload_go |=> mc_r == $past(w_data_r[MC_N-1:0]))
    else $error("preload value not taken");
  sig_read_a: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT &&
                               AXI_ARADDR_IN == SIG_HI_OFS
                               |=> AXI_RVALID_OUT && AXI_RDATA_OUT == $past(sig_r[63:32]))
    else $error("signature read wrong");
  secure_block_a: assert property (secure_r && wr_go && aw_addr_r == PRELOAD_OFS
                                   && !win_busy && !clk_rise |=> $stable(mc_r) &&
                                   AXI_BRESP_OUT == RESP_SLVERR)
    else $error("preload accepted while secured");
  pd_freeze_a: assert property (pd_act |=> $stable(mc_r) && $stable(IO_OUT)
                                && $stable(ARRAY_OUT))
    else $error("state moved during power-down");
  hiz_hold_a: assert property (pd_act |=> $stable(IO_OE_OUT))
    else $error("output enable moved during power-down");
  shared_mask_a: assert property (pd_en_r && !pd_act |=> !ARRAY_OUT[SHARED_IDX])
    else $error("shared pin reached the array while enabled");
  normal_input_a: assert property (!pd_en_r |=> ARRAY_OUT[SHARED_IDX] ==
                                   $past(in_level[SHARED_IDX]))
    else $error("shared pin not a plain input");
  resume_run_a: assert property (!pd_act && !win_busy && clk_rise && !preload_go
                                 |=> mc_r == $past(MC_D_IN))
    else $error("clocked update lost after power-down");

endmodule

// file: src/powerup_window.sv
module powerup_window #(
  parameter int CYCLES = 250
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Window state
  output logic      busy_out
);

  logic [$clog2(CYCLES+1)-1:0] cnt_r;

  // ---------------------------------------------------------------
  // Count the reset window down after the supply trip releases
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r    <= ($clog2(CYCLES+1))'(CYCLES);
      busy_out <= 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r    <= cnt_r - 1'b1;
      busy_out <= (cnt_r > ($clog2(CYCLES+1))'(1));
    end else begin
      busy_out <= 1'b0;
    end
  end

endmodule

// file: tb/board_model.sv
module board_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Requests from the bench
  input  wire logic        pulse_in,
  input  wire logic [9:0]  d_in,
  input  wire logic [21:0] val_in,
  input  wire logic [21:0] drv_in,
  // Board-side pins
  output logic             clk_pin_out,
  output logic [9:0]       d_out,
  output logic [21:0]      pin_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0]  phase_r = 3'h0;
  logic [9:0]  d_r     = 10'h000;
  logic [21:0] last_r  = 22'h000000;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_r <= 3'h0;
    end else if (phase_r != 3'h0) begin
      phase_r <= (phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
    end else if (pulse_in) begin
      phase_r <= 3'h1;
    end
  end

  // Data is set two cycles ahead of the rising pin edge to meet setup
  always_ff @(posedge clk_in) begin
    if (pulse_in && phase_r == 3'h0) begin
      d_r <= d_in;
    end
  end

  always_ff @(posedge clk_in) begin
    last_r <= (drv_in & val_in) | (~drv_in & last_r);
  end

  assign d_out = d_r;
  // Pin clock stands low outside a requested pulse, so never moves in the window
  assign clk_pin_out = (phase_r == 3'h3) || (phase_r == 3'h4);
  // A released pin shows the inverse of its last level: only the keeper may hold it
  assign pin_out = (drv_in & val_in) | (~drv_in & ~last_r);
endmodule

// file: tb/tb.sv
module tb
  import pld_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 0, rst = 1, pulse = 0;
  logic [7:0] aw_addr = 0, ar_addr = 0;
  logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0;
  logic [31:0] w_data = 0;
  logic [3:0] w_strb = 0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, clk_pin, pd_out;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data, r32;
  logic [21:0] pin_val = 0, pin_drv = 0, pin_w, arr;
  logic [9:0] d_val = 0, oe_term = 0, mc_d, io_out, io_oe, mc_e, pol_e, io_e, oe_e;
  logic [11:0] in_e;
  logic [63:0] sig;
  logic [31:0] seed = 32'h7B6210BC;
  int bad_count = 0, total_checks = 0;

  always #2 mclk = ~mclk;

  board_model board (.clk_in(mclk), .rst_in(rst), .pulse_in(pulse), .d_in(d_val),
    .val_in(pin_val), .drv_in(pin_drv), .clk_pin_out(clk_pin), .d_out(mc_d),
    .pin_out(pin_w));

  pld_powerdown_reset_control #(.RST_CYC(4)) dut (.MCLK_IN(mclk), .RST_IN(rst),
    .AXI_AWADDR_IN(aw_addr), .AXI_AWVALID_IN(aw_valid), .AXI_AWREADY_OUT(aw_ready),
    .AXI_WDATA_IN(w_data), .AXI_WSTRB_IN(w_strb), .AXI_WVALID_IN(w_valid),
    .AXI_WREADY_OUT(w_ready), .AXI_BRESP_OUT(b_resp), .AXI_BVALID_OUT(b_valid),
    .AXI_BREADY_IN(b_ready), .AXI_ARADDR_IN(ar_addr), .AXI_ARVALID_IN(ar_valid),
    .AXI_ARREADY_OUT(ar_ready), .AXI_RDATA_OUT(r_data), .AXI_RRESP_OUT(r_resp),
    .AXI_RVALID_OUT(r_valid), .AXI_RREADY_IN(r_ready), .CLK_PIN_IN(clk_pin),
    .IN_PIN_IN(pin_w[11:0]), .IN_DRIVEN_IN(pin_drv[11:0]), .IO_PIN_IN(pin_w[21:12]),
    .IO_DRIVEN_IN(pin_drv[21:12]), .IO_OUT(io_out), .IO_OE_OUT(io_oe), .MC_D_IN(mc_d),
    .OE_TERM_IN(oe_term), .ARRAY_OUT(arr), .POWER_DOWN_OUT(pd_out));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string s);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s resp %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic timeout();
    bad_count++;
    $display("[FAIL] %0t bus wait limit used up", $time);
    stop_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic note(input string s);
    $display("test done: %s", s);
  endtask

  // ---------------------------------------------------------------
  // Register bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    aw_addr <= a;
    w_data <= d;
    w_strb <= 4'hF;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid) begin
        b_ready <= 1'b0;
        chk_resp(b_resp, er, "write");
        break;
      end
    end
    if (n == 100) timeout();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp,
                     input string s);
    int n;
    @(posedge mclk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid) begin
        r_ready <= 1'b0;
        chk_resp(r_resp, er, s);
        chk_word(r_data, exp, s);
        break;
      end
    end
    if (n == 100) timeout();
  endtask

  task automatic clk_edge(input logic [9:0] d);
    @(posedge mclk);
    d_val <= d;
    pulse <= 1'b1;
    @(posedge mclk);
    pulse <= 1'b0;
    cyc(8);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rdc(STATUS_OFS, RESP_OKAY, 32'h0000_0002, "window");
    cyc(8);
    rdc(STATUS_OFS, RESP_OKAY, 32'h0000_0000, "cleared");
    chk_word({22'h0, io_out}, 32'h0, "pins after reset");
    r32 = rnd();
    pol_e = r32[9:0];
    wr(POL_OFS, {22'h0, pol_e}, RESP_OKAY);
    cyc(3);
    chk_word({22'h0, io_out}, {22'h0, pol_e}, "polarity");
    rdc(POL_OFS, RESP_OKAY, {22'h0, pol_e}, "polarity readback");
    note("reset");
    r32 = rnd() | 32'h0000_0008;
    pin_val <= r32[21:0];
    pin_drv <= 22'h3FFFFF;
    cyc(4);
    chk_word({10'h0, arr}, {10'h0, r32[21:0]}, "shared pin as input");
    chk_word({31'h0, pd_out}, 32'h0, "no sleep while disabled");
    pin_drv <= 22'h000000;
    pin_val <= ~r32[21:0];
    cyc(4);
    chk_word({10'h0, arr}, {10'h0, r32[21:0]}, "keepers hold");
    note("keepers");
    for (int i = 0; i < 3; i++) begin
      r32 = rnd();
      mc_e = (i == 0) ? 10'h3FF : r32[9:0];
      wr(PRELOAD_OFS, {22'h0, mc_e}, RESP_OKAY);
      cyc(2);
      rdc(STATUS_OFS, RESP_OKAY, {6'h0, mc_e, 16'h0}, "preload");
      chk_word({22'h0, io_out}, {22'h0, mc_e ^ pol_e}, "pins");
    end
    r32 = rnd();
    clk_edge(r32[9:0]);
    mc_e = r32[9:0];
    rdc(STATUS_OFS, RESP_OKAY, {6'h0, mc_e, 16'h0}, "clock pin");
    note("preload and clock");
    sig = {rnd(), rnd()};
    wr(SIG_LO_OFS, sig[31:0], RESP_OKAY);
    wr(SIG_HI_OFS, sig[63:32], RESP_OKAY);
    rdc(SIG_LO_OFS, RESP_OKAY, sig[31:0], "sig lo");
    rdc(SIG_HI_OFS, RESP_OKAY, sig[63:32], "sig hi");
    rdc(8'h20, RESP_SLVERR, 32'h0, "unmapped");
    wr(STATUS_OFS, 32'hFFFF_FFFF, RESP_SLVERR);
    note("signature");
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    rdc(CTRL_OFS, RESP_OKAY, 32'h0000_0001, "ctrl readback");
    r32 = rnd();
    in_e = r32[11:0] & ~12'h008;
    io_e = r32[21:12];
    oe_e = r32[31:22];
    oe_term <= oe_e;
    pin_val <= {io_e, in_e};
    pin_drv <= 22'h3FFFFF;
    cyc(4);
    pin_val <= {io_e, in_e | 12'h008};
    cyc(4);
    chk_word({31'h0, pd_out}, 32'h1, "sleep entered");
    rdc(STATUS_OFS, RESP_OKAY, {6'h0, mc_e, 16'h1}, "sleep status");
    oe_term <= ~oe_e;
    pin_val <= {~io_e, ~in_e};
    r32 = rnd();
    clk_edge(r32[9:0]);
    wr(PRELOAD_OFS, {22'h0, ~mc_e}, RESP_SLVERR);
    chk_word({22'h0, io_out}, {22'h0, mc_e ^ pol_e}, "outputs held");
    chk_word({22'h0, io_oe}, {22'h0, oe_e}, "enables held");
    chk_word({10'h0, arr}, {10'h0, io_e, in_e}, "inputs blocked");
    pin_val <= {~io_e, ~in_e & ~12'h008};
    cyc(4);
    chk_word({31'h0, pd_out}, 32'h0, "sleep left");
    chk_word({10'h0, arr}, {10'h0, ~io_e, ~in_e & ~12'h008}, "keepers tracked");
    rdc(STATUS_OFS, RESP_OKAY, {6'h0, mc_e, 16'h0}, "state kept");
    clk_edge(r32[9:0]);
    mc_e = r32[9:0];
    rdc(STATUS_OFS, RESP_OKAY, {6'h0, mc_e, 16'h0}, "clocking resumed");
    note("power-down");
    wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
    wr(PRELOAD_OFS, 32'h0, RESP_SLVERR);
    rdc(CTRL_OFS, RESP_SLVERR, 32'h0, "ctrl secured");
    rdc(SIG_HI_OFS, RESP_OKAY, sig[63:32], "sig secured");
    rdc(STATUS_OFS, RESP_OKAY, {6'h0, mc_e, 16'h4}, "secured");
    note("security");
    stop_test();
  end
endmodule
